// ---- design/lbx_consts.vh ----
// opcode encodings and sizing constants for the ladder bit executor
`ifndef LBX_CONSTS_VH
`define LBX_CONSTS_VH
// ==========================================
// opcode field (instruction bits [20:16])
`define LBX_OP_W 5
`define LBX_OP_NOP 5'h00
`define LBX_OP_END 5'h01
`define LBX_OP_ILK 5'h02
`define LBX_OP_ILC 5'h03
`define LBX_OP_JMP 5'h04
`define LBX_OP_JME 5'h05
`define LBX_OP_FAL 5'h06
`define LBX_OP_SEVERE_FAILURE_ALARM 5'h07
`define LBX_OP_STEP 5'h08
`define LBX_OP_SADV 5'h09
`define LBX_OP_KEEP 5'h0b
`define LBX_OP_UDC 5'h0c
`define LBX_OP_LD 5'h10
`define LBX_OP_LDN 5'h11
`define LBX_OP_AND 5'h12
`define LBX_OP_ANDN 5'h13
`define LBX_OP_OR 5'h14
`define LBX_OP_ORN 5'h15
`define LBX_OP_BAND 5'h16
`define LBX_OP_BOR 5'h17
`define LBX_OP_OUT 5'h18
`define LBX_OP_OUTN 5'h19
`define LBX_OP_SET 5'h1a
`define LBX_OP_CLR 5'h1b
`define LBX_OP_TIM 5'h1c
// ==========================================
// field positions
`define LBX_OP_HI 20
`define LBX_OP_LO 16
`define LBX_NOBIT_POS 15
`define LBX_INSN_W 21
// ==========================================
// sizes
`define LBX_ADDR_W 10
`define LBX_PC_W 10
`define LBX_STACK_D 8
`define LBX_PV_W 16
`define LBX_PV_INIT 16'h0064
`define LBX_CTR_N 16
`endif

// ---- design/lbx_pv_bank.v ----
// present value bank for timers and up/down counters
`include "lbx_consts.vh"
`default_nettype none
module lbx_pv_bank #(
  parameter N = `LBX_CTR_N,
  parameter W = `LBX_PV_W,
  parameter [15:0] INIT = `LBX_PV_INIT
) (
  // clock and reset
  input wire clock,
  input wire reset,
  // access
  input wire [3:0] idx,
  input wire load,
  input wire dec,
  input wire inc,
  output wire [W-1:0] pv,
  output wire zero
);
  reg [W-1:0] pv_reg [0:N-1];
  integer i;
  assign pv = pv_reg[idx];
  assign zero = (pv_reg[idx] == {W{1'b0}});
  always @(posedge clock) begin
    if (reset) begin
      for (i = 0; i < N; i = i + 1) begin
        pv_reg[i] <= INIT[W-1:0];
      end
    end else if (load) begin
      pv_reg[idx] <= INIT[W-1:0];
    end else if (inc && !dec) begin
      // wraps at all ones: plain binary count
      pv_reg[idx] <= pv_reg[idx] + {{(W-1){1'b0}}, 1'b1};
    end else if (dec && !inc && !zero) begin
      pv_reg[idx] <= pv_reg[idx] - {{(W-1){1'b0}}, 1'b1};
    end
  end
endmodule
`default_nettype wire

// ---- design/lbx_executor.v ----
// ladder bit logic executor: sequential scan of a stored program over bit memory
// Functional notes
// - AND: condition ANDed with addressed bit
// - AND inverted: condition ANDed with bit complement
// - OR: condition ORed with addressed bit
// - OR inverted: condition ORed with bit complement
// - block_and merges last two blocks by AND
// - block_or merges last two blocks by OR
// - inverted_load starts line with bit complement
// - output writes bit equal to condition
// - inverted output writes bit complement of condition
// - bit_clear clears bit when condition ON
// - set sets bit when condition ON
// - no_operation only advances program position
// - interlock OFF forces outputs off, resets timers
// - interlock OFF keeps counter present values
// - skip region skipped when condition OFF
// - minor_failure_alarm flags non-fatal error with number
// - severe_failure_alarm flags fatal error with number
// - step define starts step or ends stepping
// - step_advance ends, resets step, starts next
// - latch set by set, cleared by reset
// - up_down_counter counts input rising edges
// - timer counts present value down while ON
`include "lbx_consts.vh"
`default_nettype none
module lbx_executor #(
  parameter AW = `LBX_ADDR_W,
  parameter PW = `LBX_PC_W,
  parameter SD = `LBX_STACK_D
) (
  // clock and reset
  input wire clock,
  input wire reset,
  // program memory read port (same clock, one cycle latency)
  output reg [PW-1:0] prog_addr_reg,
  input wire [`LBX_INSN_W-1:0] prog_data,
  // external bit inputs (pins)
  input wire [15:0] in_pins,
  // run control
  input wire run,
  // status
  output reg [15:0] out_pins_reg,
  output reg minor_err_reg,
  output reg severe_err_reg,
  output reg [7:0] alarm_num_reg,
  output reg scan_done_reg
);
  // ==========================================
  // state machine
  localparam [2:0] S_FETCH = 3'b001;
  localparam [2:0] S_EXEC = 3'b010;
  localparam [2:0] S_HALT = 3'b100;
  reg [2:0] state_reg;
  reg [(1<<AW)-1:0] bits_reg;
  reg cond_reg;
  reg [SD-1:0] stk_reg;
  reg [3:0] sp_reg;
  reg ilk_off_reg;
  reg skip_reg;
  reg prev_step_vld_reg;
  reg [AW-1:0] prev_step_reg;
  reg [15:0] in_s1_reg;
  reg [15:0] in_s2_reg;
  reg [15:0] cedge_reg;
  // ==========================================
  // decode
  wire [`LBX_OP_W-1:0] op = prog_data[`LBX_OP_HI:`LBX_OP_LO];
  wire [AW-1:0] opa = prog_data[AW-1:0];
  wire no_bit = prog_data[`LBX_NOBIT_POS];
  wire [3:0] cidx = prog_data[13:10];
  wire bit_v = bits_reg[opa];
  wire nxt_v = bits_reg[opa + {{(AW-1){1'b0}}, 1'b1}];
  // region-end opcodes are still honoured while skipping
  function is_region_end;
    input [`LBX_OP_W-1:0] o;
    begin
      is_region_end = (o == `LBX_OP_JME) || (o == `LBX_OP_END);
    end
  endfunction
  wire live = (state_reg == S_EXEC) && (!skip_reg || is_region_end(op));
  wire ilk_gate = !ilk_off_reg;
  // ==========================================
  // present value bank
  wire [`LBX_PV_W-1:0] pv;
  wire pv_zero;
  reg pv_load;
  reg pv_dec;
  reg pv_inc;
  lbx_pv_bank u_pv (
    .clock(clock),
    .reset(reset),
    .idx(cidx),
    .load(pv_load),
    .dec(pv_dec),
    .inc(pv_inc),
    .pv(pv),
    .zero(pv_zero)
  );
  always @* begin
    pv_load = 1'b0;
    pv_dec = 1'b0;
    pv_inc = 1'b0;
    if (live && op == `LBX_OP_TIM) begin
      if (!cond_reg || ilk_off_reg) begin
        pv_load = 1'b1;
      end else begin
        pv_dec = 1'b1;
      end
    end else if (live && op == `LBX_OP_UDC && ilk_gate) begin
      // counter untouched under interlock
      pv_inc = cond_reg && cedge_reg[cidx];
      pv_dec = bit_v && cedge_reg[cidx];
      pv_load = nxt_v; // reset input
    end
  end
  // ==========================================
  // two-stage pin synchroniser
  always @(posedge clock) begin
    if (reset) begin
      in_s1_reg <= 16'h0000;
      in_s2_reg <= 16'h0000;
    end else begin
      in_s1_reg <= in_pins;
      in_s2_reg <= in_s1_reg;
    end
  end
  // ==========================================
  // execution
  always @(posedge clock) begin
    if (reset) begin
      state_reg <= S_FETCH;
      prog_addr_reg <= {PW{1'b0}};
      bits_reg <= {(1<<AW){1'b0}};
      cond_reg <= 1'b0;
      stk_reg <= {SD{1'b0}};
      sp_reg <= 4'h0;
      ilk_off_reg <= 1'b0;
      skip_reg <= 1'b0;
      prev_step_vld_reg <= 1'b0;
      prev_step_reg <= {AW{1'b0}};
      cedge_reg <= 16'h0000;
      out_pins_reg <= 16'h0000;
      minor_err_reg <= 1'b0;
      severe_err_reg <= 1'b0;
      alarm_num_reg <= 8'h00;
      scan_done_reg <= 1'b0;
    end else begin
      scan_done_reg <= 1'b0;
      case (state_reg)
        S_FETCH: begin
          if (run && !severe_err_reg) begin
            state_reg <= S_EXEC;
          end
        end
        S_EXEC: begin
          state_reg <= S_FETCH;
          prog_addr_reg <= prog_addr_reg + {{(PW-1){1'b0}}, 1'b1};
          if (live) begin
            case (op)
              `LBX_OP_NOP: begin
              end
              `LBX_OP_END: begin
                prog_addr_reg <= {PW{1'b0}};
                scan_done_reg <= 1'b1;
                ilk_off_reg <= 1'b0;
                skip_reg <= 1'b0;
                prev_step_vld_reg <= 1'b0;
                sp_reg <= 4'h0;
                // inputs refresh between scans, like an image table
                bits_reg[15:0] <= in_s2_reg;
                out_pins_reg <= bits_reg[31:16];
              end
              `LBX_OP_LD: begin
                cond_reg <= bit_v;
                stk_reg <= {stk_reg[SD-2:0], cond_reg};
                sp_reg <= sp_reg + 4'h1;
              end
              `LBX_OP_LDN: begin
                cond_reg <= !bit_v;
                stk_reg <= {stk_reg[SD-2:0], cond_reg};
                sp_reg <= sp_reg + 4'h1;
              end
              `LBX_OP_AND: cond_reg <= cond_reg & bit_v;
              `LBX_OP_ANDN: cond_reg <= cond_reg & !bit_v;
              `LBX_OP_OR: cond_reg <= cond_reg | bit_v;
              `LBX_OP_ORN: cond_reg <= cond_reg | !bit_v;
              `LBX_OP_BAND: begin
                cond_reg <= cond_reg & stk_reg[0];
                stk_reg <= {1'b0, stk_reg[SD-1:1]};
                sp_reg <= sp_reg - 4'h1;
              end
              `LBX_OP_BOR: begin
                cond_reg <= cond_reg | stk_reg[0];
                stk_reg <= {1'b0, stk_reg[SD-1:1]};
                sp_reg <= sp_reg - 4'h1;
              end
              `LBX_OP_OUT: bits_reg[opa] <= cond_reg & ilk_gate;
              `LBX_OP_OUTN: bits_reg[opa] <= !cond_reg & ilk_gate;
              `LBX_OP_SET: begin
                if (cond_reg && ilk_gate) begin
                  bits_reg[opa] <= 1'b1;
                end
              end
              `LBX_OP_CLR: begin
                if (cond_reg && ilk_gate) begin
                  bits_reg[opa] <= 1'b0;
                end
              end
              `LBX_OP_ILK: ilk_off_reg <= !cond_reg;
              `LBX_OP_ILC: ilk_off_reg <= 1'b0;
              `LBX_OP_JMP: skip_reg <= !cond_reg;
              `LBX_OP_JME: skip_reg <= 1'b0;
              `LBX_OP_FAL: begin
                if (cond_reg) begin
                  minor_err_reg <= 1'b1;
                  alarm_num_reg <= prog_data[7:0];
                end
              end
              `LBX_OP_SEVERE_FAILURE_ALARM: begin
                if (cond_reg) begin
                  severe_err_reg <= 1'b1;
                  alarm_num_reg <= prog_data[7:0];
                end
              end
              `LBX_OP_STEP: begin
                if (no_bit) begin
                  prev_step_vld_reg <= 1'b0;
                end else begin
                  if (prev_step_vld_reg && prev_step_reg != opa) begin
                    bits_reg[prev_step_reg] <= 1'b0;
                  end
                  prev_step_reg <= opa;
                  prev_step_vld_reg <= 1'b1;
                  cond_reg <= bit_v;
                end
              end
              `LBX_OP_SADV: begin
                if (cond_reg && ilk_gate) begin
                  bits_reg[opa] <= 1'b0;
                  bits_reg[opa + {{(AW-1){1'b0}}, 1'b1}] <= 1'b1;
                end
              end
              `LBX_OP_KEEP: begin
                // reset input dominates a simultaneous set
                if (ilk_gate) begin
                  if (stk_reg[0]) begin
                    bits_reg[opa] <= 1'b0;
                  end else if (cond_reg) begin
                    bits_reg[opa] <= 1'b1;
                  end
                end
                stk_reg <= {1'b0, stk_reg[SD-1:1]};
                sp_reg <= sp_reg - 4'h1;
              end
              `LBX_OP_UDC: begin
                cedge_reg[cidx] <= !(cond_reg | bit_v);
                bits_reg[opa + {{(AW-2){1'b0}}, 2'b10}] <= pv_zero;
              end
              `LBX_OP_TIM: begin
                bits_reg[opa] <= cond_reg && ilk_gate &&
                  (pv == {{(`LBX_PV_W-1){1'b0}}, 1'b1} || pv_zero);
              end
              default: begin
              end
            endcase
          end
        end
        S_HALT: state_reg <= S_HALT;
        default: state_reg <= S_FETCH;
      endcase
    end
  end
endmodule
`default_nettype wire

// ---- sim/lbx_prog_model.sv ----
// program memory model feeding the executor fetch port
`default_nettype none
module lbx_prog_model (
  // clock
  input wire logic clock,
  // bench load port
  input wire logic we,
  input wire logic [9:0] wa,
  input wire logic [20:0] wd,
  // fetch port
  input wire logic [9:0] addr,
  output logic [20:0] data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [20:0] mem [0:1023];
  // combinational read holds steady through the exec cycle
  assign data = mem[addr];
  always @(posedge clock) begin
    if (we) begin
      mem[wa] <= wd;
    end
  end
endmodule
`default_nettype wire

// ---- sim/lbx_exec_assertions.sv ----
// port checker for the ladder executor
`default_nettype none
module lbx_exec_chk #(parameter PW = 10) (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // program port and inputs
  input wire logic [PW-1:0] prog_addr_reg,
  input wire logic [20:0] prog_data,
  input wire logic [15:0] in_pins,
  input wire logic run,
  // status
  input wire logic [15:0] out_pins_reg,
  input wire logic minor_err_reg,
  input wire logic severe_err_reg,
  input wire logic [7:0] alarm_num_reg,
  input wire logic scan_done_reg
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  // ==========================================
  // assertions
  done_pulse_a: assert property (scan_done_reg |=> !scan_done_reg)
    else $error("scan done longer than one cycle");
  scan_wrap_a: assert property (scan_done_reg |-> ##[0:2] prog_addr_reg == '0)
    else $error("scan did not restart at zero");
  pc_step_a: assert property ($changed(prog_addr_reg) |->
    prog_addr_reg == $past(prog_addr_reg) + 1'b1 || prog_addr_reg == '0)
    else $error("program position jumped");
  rst_clear_a: assert property (disable iff (1'b0) reset |=> out_pins_reg == 16'h0000
    && !minor_err_reg && !severe_err_reg && !scan_done_reg)
    else $error("outputs not cleared by reset");
  minor_hold_a: assert property (minor_err_reg |=> minor_err_reg)
    else $error("minor error dropped");
  severe_hold_a: assert property (severe_err_reg |=> severe_err_reg)
    else $error("severe error dropped");
  severe_halt_a: assert property (severe_err_reg && $past(severe_err_reg) |->
    $stable(prog_addr_reg))
    else $error("fetch after severe error");
  alarm_src_a: assert property ($changed(alarm_num_reg) |->
    minor_err_reg || severe_err_reg)
    else $error("alarm number without error");
  out_at_end_a: assert property ($changed(out_pins_reg) |-> scan_done_reg)
    else $error("outputs changed outside end");
  // ==========================================
  // covers
  scan_c: cover property (scan_done_reg);
  minor_c: cover property ($rose(minor_err_reg));
  severe_c: cover property ($rose(severe_err_reg));
endmodule
bind lbx_executor lbx_exec_chk #(.PW(PW)) chk (.clock(clock), .reset(reset),
  .prog_addr_reg(prog_addr_reg), .prog_data(prog_data), .in_pins(in_pins), .run(run),
  .out_pins_reg(out_pins_reg), .minor_err_reg(minor_err_reg),
  .severe_err_reg(severe_err_reg), .alarm_num_reg(alarm_num_reg),
  .scan_done_reg(scan_done_reg));
`default_nettype wire

// ---- sim/lbx_testbench.sv ----
// self-checking bench for the ladder executor
`default_nettype none
`include "lbx_consts.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic run = 1'b0;
  logic [15:0] in_pins = 16'h0000;
  logic we = 1'b0;
  logic [9:0] wa = 10'h000;
  logic [20:0] wd = 21'h000000;
  wire logic [9:0] pa;
  wire logic [20:0] pd;
  wire logic [15:0] outp;
  wire logic mn;
  wire logic sv;
  wire logic [7:0] an;
  wire logic sd;
  int num_errors = 0;
  int tests_run = 0;
  int cyc = 0;
  logic [20:0] q[$];
  logic [9:0] pa_seen;
  always #12.5 clock = ~clock;
  lbx_executor uut (.clock(clock), .reset(reset), .prog_addr_reg(pa), .prog_data(pd),
    .in_pins(in_pins), .run(run), .out_pins_reg(outp), .minor_err_reg(mn),
    .severe_err_reg(sv), .alarm_num_reg(an), .scan_done_reg(sd));
  lbx_prog_model prog (.clock(clock), .we(we), .wa(wa), .wd(wd), .addr(pa), .data(pd));
  // ==========================================
  // helpers
  function automatic logic [20:0] w(input logic [4:0] op, input logic [9:0] a);
    return {op, 6'h00, a};
  endfunction
  // reset is held over the whole load so no stale fetch runs
  task automatic boot(input logic [15:0] pins);
    int i;
    @(posedge clock);
    reset <= 1'b1;
    run <= 1'b0;
    in_pins <= pins;
    for (i = 0; i < q.size(); i++) begin
      @(posedge clock);
      we <= 1'b1;
      wa <= i[9:0];
      wd <= q[i];
    end
    @(posedge clock);
    we <= 1'b0;
    repeat (5) @(posedge clock);
    reset <= 1'b0;
    run <= 1'b1;
  endtask
  task automatic scans(input int n);
    repeat (n) @(negedge clock iff sd === 1'b1);
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // ==========================================
  // scenarios
  task automatic t_logic();
    q = '{w(`LBX_OP_LD, 0), w(`LBX_OP_AND, 1), w(`LBX_OP_OUT, 16),
      w(`LBX_OP_LD, 0), w(`LBX_OP_ANDN, 1), w(`LBX_OP_OUT, 17),
      w(`LBX_OP_LD, 1), w(`LBX_OP_OR, 0), w(`LBX_OP_OUT, 18),
      w(`LBX_OP_LD, 1), w(`LBX_OP_ORN, 0), w(`LBX_OP_OUT, 19),
      w(`LBX_OP_LDN, 1), w(`LBX_OP_OUT, 20),
      w(`LBX_OP_LD, 0), w(`LBX_OP_LD, 1), w(`LBX_OP_BAND, 0), w(`LBX_OP_OUT, 21),
      w(`LBX_OP_LD, 0), w(`LBX_OP_LD, 1), w(`LBX_OP_BOR, 0), w(`LBX_OP_OUT, 22),
      w(`LBX_OP_LD, 0), w(`LBX_OP_OUTN, 23),
      w(`LBX_OP_LD, 0), w(`LBX_OP_SET, 24), w(`LBX_OP_LD, 1), w(`LBX_OP_SET, 25),
      w(`LBX_OP_LD, 1), w(`LBX_OP_CLR, 24), w(`LBX_OP_LD, 0), w(`LBX_OP_SET, 26),
      w(`LBX_OP_LD, 0), w(`LBX_OP_CLR, 26),
      w(`LBX_OP_LD, 1), w(`LBX_OP_LD, 0), w(`LBX_OP_KEEP, 27),
      w(`LBX_OP_LD, 0), w(`LBX_OP_SADV, 28), w(`LBX_OP_NOP, 0), w(`LBX_OP_END, 0)};
    boot(16'h0001);
    scans(3);
    check(outp, 16'h2956);
  endtask
  task automatic t_regions();
    q = '{w(`LBX_OP_LD, 1), w(`LBX_OP_ILK, 0), w(`LBX_OP_LD, 0), w(`LBX_OP_OUT, 16),
      w(`LBX_OP_ILC, 0), w(`LBX_OP_LD, 1), w(`LBX_OP_JMP, 0), w(`LBX_OP_LD, 0),
      w(`LBX_OP_OUT, 17), w(`LBX_OP_JME, 0), w(`LBX_OP_LD, 0), w(`LBX_OP_JMP, 0),
      w(`LBX_OP_LD, 0), w(`LBX_OP_OUT, 18), w(`LBX_OP_JME, 0), w(`LBX_OP_END, 0)};
    boot(16'h0001);
    scans(3);
    check(outp, 16'h0004);
  endtask
  task automatic t_alarms();
    q = '{w(`LBX_OP_LD, 0), w(`LBX_OP_FAL, 10'h02a), w(`LBX_OP_END, 0)};
    boot(16'h0001);
    scans(3);
    check({15'h0000, mn}, 16'h0001);
    check({15'h0000, sv}, 16'h0000);
    check({8'h00, an}, 16'h002a);
    q = '{w(`LBX_OP_LD, 0), w(`LBX_OP_SEVERE_FAILURE_ALARM, 10'h035), w(`LBX_OP_END, 0)};
    boot(16'h0001);
    scans(1);
    repeat (20) @(negedge clock);
    pa_seen = pa;
    check({15'h0000, sv}, 16'h0001);
    check({8'h00, an}, 16'h0035);
    repeat (10) @(negedge clock);
    check({6'h00, pa}, {6'h00, pa_seen});
  endtask
  task automatic t_steps();
    q = '{w(`LBX_OP_LD, 0), w(`LBX_OP_SET, 16), w(`LBX_OP_LD, 0), w(`LBX_OP_SET, 17),
      w(`LBX_OP_STEP, 16), w(`LBX_OP_STEP, 17), {`LBX_OP_STEP, 6'h20, 10'h000},
      w(`LBX_OP_END, 0)};
    boot(16'h0001);
    scans(3);
    check(outp, 16'h0002);
  endtask
  // done flag comes up in the scan that sees a present value of one
  task automatic t_timer();
    q = '{w(`LBX_OP_LD, 0), w(`LBX_OP_TIM, 16), w(`LBX_OP_END, 0)};
    boot(16'h0001);
    scans(100);
    check(outp, 16'h0000);
    scans(1);
    check(outp, 16'h0001);
  endtask
  // bit 20 toggles each scan, so one decrement lands every second scan
  task automatic t_counter();
    q = '{w(`LBX_OP_LD, 20), w(`LBX_OP_OUTN, 20), w(`LBX_OP_LD, 2),
      w(`LBX_OP_UDC, 20), w(`LBX_OP_END, 0)};
    boot(16'h0000);
    scans(190);
    check({15'h0000, outp[6]}, 16'h0000);
    scans(20);
    check({15'h0000, outp[6]}, 16'h0001);
  endtask
  initial begin
    t_logic();
    t_regions();
    t_alarms();
    t_steps();
    t_timer();
    t_counter();
    wrap_up();
  end
  // cuts a hang short
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      wrap_up();
    end
  end
endmodule
`default_nettype wire
